// *** cpu_regs_pkg.sv ***
/*
 * constants for the core register set: widths, flag positions, reset values,
 * priority codes, register selects, operation codes and push/pop sequence lengths.
 * assumes nothing beyond a systemverilog compiler.
 */
package cpu_regs_pkg;

    // ----------------------------------------------------------------
    // widths and stack geometry
    // ----------------------------------------------------------------
    localparam int        DATA_W        = 8;
    localparam int        ADDR_W        = 16;
    localparam logic [7:0] STACK_PAGE   = 8'h01;   // fixed upper stack pointer byte
    localparam logic [7:0] STACK_TOP    = 8'hff;   // low byte after reset
    localparam int        CALL_BYTES    = 2;
    localparam int        IRQ_BYTES     = 5;

    // ----------------------------------------------------------------
    // condition flag bit positions and reset value
    // ----------------------------------------------------------------
    localparam int FLAG_CARRY    = 0;
    localparam int FLAG_ZERO     = 1;
    localparam int FLAG_NEG      = 2;
    localparam int FLAG_PRIO_LO  = 3;
    localparam int FLAG_HALF     = 4;
    localparam int FLAG_PRIO_HI  = 5;
    localparam logic [7:0] FLAGS_ONES  = 8'hc0;    // bits 7 and 6 always read one
    localparam logic [7:0] FLAGS_RESET = 8'hf8;    // undefined reset bits: half carry taken as one, negative, zero and carry as zero

    // ----------------------------------------------------------------
    // priority level codes {high bit, low bit}
    // ----------------------------------------------------------------
    localparam logic [1:0] PRIO_LEVEL0 = 2'h2;
    localparam logic [1:0] PRIO_LEVEL1 = 2'h1;
    localparam logic [1:0] PRIO_LEVEL2 = 2'h0;
    localparam logic [1:0] PRIO_LEVEL3 = 2'h3;     // interrupts disabled

    // ----------------------------------------------------------------
    // register selects for the instruction port
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SEL_ACC, SEL_INDEX, SEL_PC_LOW, SEL_PC_HIGH, SEL_FLAGS, SEL_STACK_LOW
    } reg_sel_t;

    // ----------------------------------------------------------------
    // operations requested by the instruction decoder
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE,        // hold
        OP_ADD,         // acc = acc + operand
        OP_ADC,         // acc = acc + operand + carry
        OP_LOGIC,       // acc = result_i, logic / data manipulation
        OP_LOAD,        // write dest_sel with operand
        OP_SET_CARRY,
        OP_CLR_CARRY,
        OP_CARRY_LOAD,  // carry from bit test, shift or rotate
        OP_SET_PRIO,    // priority bits from operand (unmask/mask/halt/wait)
        OP_STACK_RESET,
        OP_PUSH,        // push dest_sel register (acc, index or flags; any other select pushes acc)
        OP_POP,         // pop into dest_sel register (acc, index or flags; other selects write nothing)
        OP_CALL,        // push pc low, pc high, jump
        OP_RET,         // pop pc high, pc low
        OP_IRQ,         // five byte context save, jump
        OP_INTERRUPT_RETURN_INSTR         // five byte context restore
    } op_t;

endpackage : cpu_regs_pkg

// *** cpu_core_register_set.sv ***
/*
 * core register set: accumulator, two index registers, program counter,
 * condition flags and stack pointer, with the stack push/pop sequencer.
 * assumes an instruction decoder drives op_i for one cycle while busy_o is low,
 * and a stack memory that accepts stack_we_o writes and returns stack_rdata_i
 * combinationally for stack_addr_o.
 */
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// RULE1: registers are unmapped; reached only through instruction operations on this port.
// RULE2: an 8-bit accumulator holds operands and results.
// RULE3: two 8-bit index registers hold addresses or temporary data.
// RULE4: a prefix byte makes the next instruction use the second index register.
// RULE5: interrupt entry and return never save or restore the second index register.
// RULE6: 16-bit program counter built from low and high bytes.
// RULE7: flags hold two priority bits, four result flags; bits 7,6 read one.
// RULE8: half carry set on carry from bit 3 to 4 in add and add-carry.
// RULE9: negative flag copies result bit 7.
// RULE10: zero flag set when result is zero.
// RULE11: carry shows overflow, forced by set/clear, loaded by test, shift, rotate.
// RULE12: priority codes: level0 10, level1 01, level2 00, level3 11 disabled.
// RULE13: interrupt entry loads priority from source; some instructions also change it.
// RULE14: stack pointer addresses next free byte; decrement after push, increment before pop.
// RULE15: stack is 256 bytes; upper pointer byte fixed by hardware.
// RULE16: reset or stack reset sets all eight low pointer bits.
// RULE17: low pointer byte directly loadable and readable.
// RULE18: pointer wraps silently at both stack limits.
// RULE19: interrupt pushes pc low first, rest lower; return pops in reverse.
// RULE20: a call uses two stack bytes, an interrupt five.
// RULE21: interrupt order: pc low, pc high, index, accumulator, flags.
module cpu_core_register_set
    import cpu_regs_pkg::*;
#(
    parameter int DW = cpu_regs_pkg::DATA_W
) (
    input  wire logic                       clock_i,        // core clock
    input  wire logic                       rst_i,          // mcu reset, sync high
    input  wire cpu_regs_pkg::op_t          op_i,           // operation, one cycle
    input  wire cpu_regs_pkg::reg_sel_t     dest_sel_i,     // register for load/push/pop/read
    input  wire logic                       prefix_i,       // prefix seen: use second index
    input  wire logic [7:0]                 operand_i,      // operand or load data
    input  wire logic [7:0]                 result_i,       // logic result for op_logic
    input  wire logic                       carry_in_i,     // carry for op_carry_load
    input  wire logic [1:0]                 src_prio_i,     // interrupting source priority
    input  wire logic [15:0]                target_i,       // jump target for call/irq
    input  wire logic [7:0]                 stack_rdata_i,  // stack memory read data
    output logic                            busy_o,         // stack sequence running
    output logic [7:0]                      read_data_o,    // selected register
    output logic [7:0]                      acc_o,          // accumulator
    output logic [7:0]                      index_x_o,      // first index register
    output logic [7:0]                      index_y_o,      // second index register
    output logic [15:0]                     program_counter_o, // program counter
    output logic [7:0]                      condition_flags_o, // flags
    output logic [15:0]                     stack_pointer_o,   // stack pointer
    output logic [15:0]                     stack_addr_o,   // stack memory address
    output logic [7:0]                      stack_wdata_o,  // stack memory write data
    output logic                            stack_we_o      // stack memory write strobe
);
    import cpu_regs_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_POP} seq_state_t;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] sp_dec(input logic [7:0] s);
        sp_dec = s - 8'h01; // wraps to top silently
    endfunction : sp_dec

    function automatic logic [7:0] sp_inc(input logic [7:0] s);
        sp_inc = s + 8'h01; // wraps to bottom silently
    endfunction : sp_inc

    function automatic logic [7:0] nz_flags(input logic [7:0] f, input logic [7:0] r);
        logic [7:0] t;
        t = f;
        t[FLAG_NEG]  = r[7];
        t[FLAG_ZERO] = (r == 8'h00);
        nz_flags = t;
    endfunction : nz_flags

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0]  acc_reg,   acc_next;
    logic [7:0]  x_reg,     x_next;
    logic [7:0]  y_reg,     y_next;
    logic [15:0] pc_reg,    pc_next;
    logic [7:0]  flags_reg, flags_next;
    logic [7:0]  sp_reg,    sp_next;
    seq_state_t  state_reg, state_next;
    logic [2:0]  cnt_reg,   cnt_next;     // bytes left in sequence
    logic [2:0]  len_reg,   len_next;     // sequence length
    logic        ctx_reg,   ctx_next;     // sequence is call or interrupt context
    logic        sel_y_reg, sel_y_next;   // push/pop of second index
    reg_sel_t    dsel_reg,  dsel_next;
    logic [8:0]  sum;
    logic [4:0]  half;
    logic [2:0]  pos;                     // position within sequence
    logic [7:0]  push_byte;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        acc_next   = acc_reg;
        x_next     = x_reg;
        y_next     = y_reg;
        pc_next    = pc_reg;
        flags_next = flags_reg;
        sp_next    = sp_reg;
        state_next = state_reg;
        cnt_next   = cnt_reg;
        len_next   = len_reg;
        ctx_next   = ctx_reg;
        sel_y_next = sel_y_reg;
        dsel_next  = dsel_reg;
        sum        = 9'h000;
        half       = 5'h00;
        pos        = 3'(len_reg - cnt_reg);
        push_byte  = 8'h00;
        stack_we_o = 1'b0;
        stack_wdata_o = 8'h00;
        case (state_reg)
            ST_IDLE: begin
                case (op_i)
                    OP_ADD, OP_ADC: begin
                        sum  = {1'b0, acc_reg} + {1'b0, operand_i}
                             + {8'h00, (op_i == OP_ADC) & flags_reg[FLAG_CARRY]}; // RULE2
                        half = {1'b0, acc_reg[3:0]} + {1'b0, operand_i[3:0]}
                             + {4'h0, (op_i == OP_ADC) & flags_reg[FLAG_CARRY]};
                        acc_next = sum[7:0];
                        flags_next = nz_flags(flags_reg, sum[7:0]);       // RULE9 RULE10
                        flags_next[FLAG_HALF]  = half[4];                 // RULE8
                        flags_next[FLAG_CARRY] = sum[8];                  // RULE11
                    end
                    OP_LOGIC: begin
                        acc_next   = result_i;
                        flags_next = nz_flags(flags_reg, result_i);       // RULE9 RULE10
                    end
                    OP_LOAD: begin
                        if (dest_sel_i == SEL_ACC) begin
                            acc_next = operand_i;
                        end else if (dest_sel_i == SEL_INDEX && prefix_i) begin
                            y_next = operand_i;                           // RULE3 RULE4
                        end else if (dest_sel_i == SEL_INDEX) begin
                            x_next = operand_i;                           // RULE3
                        end else if (dest_sel_i == SEL_PC_LOW) begin
                            pc_next[7:0] = operand_i;                     // RULE6
                        end else if (dest_sel_i == SEL_PC_HIGH) begin
                            pc_next[15:8] = operand_i;                    // RULE6
                        end else if (dest_sel_i == SEL_FLAGS) begin
                            flags_next = operand_i | FLAGS_ONES;          // RULE7
                        end else if (dest_sel_i == SEL_STACK_LOW) begin
                            sp_next = operand_i;                          // RULE17
                        end
                        if (dest_sel_i == SEL_ACC || dest_sel_i == SEL_INDEX) begin
                            flags_next = nz_flags(flags_reg, operand_i);  // RULE9 RULE10
                        end
                    end
                    OP_SET_CARRY:   flags_next[FLAG_CARRY] = 1'b1;        // RULE11
                    OP_CLR_CARRY:   flags_next[FLAG_CARRY] = 1'b0;        // RULE11
                    OP_CARRY_LOAD:  flags_next[FLAG_CARRY] = carry_in_i;  // RULE11
                    OP_SET_PRIO: begin
                        flags_next[FLAG_PRIO_HI] = operand_i[1];          // RULE12 RULE13
                        flags_next[FLAG_PRIO_LO] = operand_i[0];
                    end
                    OP_STACK_RESET: sp_next = STACK_TOP;                  // RULE16
                    OP_PUSH, OP_CALL, OP_IRQ: begin
                        state_next = ST_PUSH;
                        len_next   = (op_i == OP_IRQ) ? 3'(IRQ_BYTES)
                                   : (op_i == OP_CALL) ? 3'(CALL_BYTES) : 3'h1; // RULE20
                        cnt_next   = len_next;
                        ctx_next   = (op_i != OP_PUSH);
                        sel_y_next = prefix_i;
                        dsel_next  = dest_sel_i;
                    end
                    OP_POP, OP_RET, OP_INTERRUPT_RETURN_INSTR: begin
                        state_next = ST_POP;
                        len_next   = (op_i == OP_INTERRUPT_RETURN_INSTR) ? 3'(IRQ_BYTES)
                                   : (op_i == OP_RET) ? 3'(CALL_BYTES) : 3'h1;  // RULE20
                        cnt_next   = len_next;
                        ctx_next   = (op_i != OP_POP);
                        sel_y_next = prefix_i;
                        dsel_next  = dest_sel_i;
                    end
                    default: ;
                endcase
            end
            ST_PUSH: begin
                // context order pc low, pc high, x, acc, flags; y never saved
                if (ctx_reg) begin
                    case (pos)
                        3'h0:    push_byte = pc_reg[7:0];                 // RULE19 RULE21
                        3'h1:    push_byte = pc_reg[15:8];                // RULE21
                        3'h2:    push_byte = x_reg;                       // RULE5 RULE21
                        3'h3:    push_byte = acc_reg;                     // RULE21
                        default: push_byte = flags_reg;                   // RULE21
                    endcase
                end else begin
                    push_byte = read_data_o;
                end
                stack_we_o    = 1'b1;
                stack_wdata_o = push_byte;
                sp_next  = sp_dec(sp_reg);                                // RULE14 RULE18
                cnt_next = cnt_reg - 3'h1;
                if (cnt_reg == 3'h1) begin
                    state_next = ST_IDLE;
                    if (ctx_reg) begin
                        pc_next = target_i;
                    end
                    if (ctx_reg && len_reg == 3'(IRQ_BYTES)) begin
                        flags_next[FLAG_PRIO_HI] = src_prio_i[1];         // RULE13
                        flags_next[FLAG_PRIO_LO] = src_prio_i[0];
                    end
                end
            end
            ST_POP: begin
                // reverse order of the push; pre-increment address
                sp_next  = sp_inc(sp_reg);                                // RULE14 RULE18
                cnt_next = cnt_reg - 3'h1;
                if (ctx_reg) begin
                    case (cnt_reg)
                        3'h5: flags_next = stack_rdata_i | FLAGS_ONES;    // RULE19 RULE13
                        3'h4: acc_next   = stack_rdata_i;
                        3'h3: x_next     = stack_rdata_i;                 // RULE5
                        3'h2: pc_next[15:8] = stack_rdata_i;
                        default: pc_next[7:0] = stack_rdata_i;
                    endcase
                    if (len_reg == 3'(CALL_BYTES) && cnt_reg == 3'h2) begin
                        pc_next[15:8] = stack_rdata_i;
                    end
                end else if (dsel_reg == SEL_ACC) begin
                    acc_next = stack_rdata_i;
                end else if (dsel_reg == SEL_INDEX && sel_y_reg) begin
                    y_next = stack_rdata_i;                               // RULE4
                end else if (dsel_reg == SEL_INDEX) begin
                    x_next = stack_rdata_i;
                end else if (dsel_reg == SEL_FLAGS) begin
                    flags_next = stack_rdata_i | FLAGS_ONES;              // RULE13
                end
                if (cnt_reg == 3'h1) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            acc_reg   <= 8'h00;
            x_reg     <= 8'h00;
            y_reg     <= 8'h00;
            pc_reg    <= 16'h0000;
            flags_reg <= FLAGS_RESET;                                     // RULE7
            sp_reg    <= STACK_TOP;                                       // RULE16
            state_reg <= ST_IDLE;
            cnt_reg   <= 3'h0;
            len_reg   <= 3'h0;
            ctx_reg   <= 1'b0;
            sel_y_reg <= 1'b0;
            dsel_reg  <= SEL_ACC;
        end else begin
            acc_reg   <= acc_next;
            x_reg     <= x_next;
            y_reg     <= y_next;
            pc_reg    <= pc_next;
            flags_reg <= flags_next | FLAGS_ONES;                         // RULE7
            sp_reg    <= sp_next;
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            len_reg   <= len_next;
            ctx_reg   <= ctx_next;
            sel_y_reg <= sel_y_next;
            dsel_reg  <= dsel_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always_comb begin
        if (dest_sel_i == SEL_ACC) begin
            read_data_o = acc_reg;
        end else if (dest_sel_i == SEL_INDEX) begin
            read_data_o = (state_reg == ST_IDLE ? prefix_i : sel_y_reg) ? y_reg : x_reg;
        end else if (dest_sel_i == SEL_PC_LOW) begin
            read_data_o = pc_reg[7:0];
        end else if (dest_sel_i == SEL_PC_HIGH) begin
            read_data_o = pc_reg[15:8];
        end else if (dest_sel_i == SEL_FLAGS) begin
            read_data_o = flags_reg;
        end else begin
            read_data_o = sp_reg;                                         // RULE17
        end
        if (state_reg == ST_PUSH && !ctx_reg) begin
            read_data_o = (dsel_reg == SEL_INDEX && sel_y_reg) ? y_reg
                        : (dsel_reg == SEL_INDEX) ? x_reg
                        : (dsel_reg == SEL_FLAGS) ? flags_reg : acc_reg;
        end
    end

    assign busy_o            = (state_reg != ST_IDLE);
    assign acc_o             = acc_reg;
    assign index_x_o         = x_reg;
    assign index_y_o         = y_reg;
    assign program_counter_o = pc_reg;
    assign condition_flags_o = flags_reg;
    assign stack_pointer_o   = {STACK_PAGE, sp_reg};                      // RULE15 RULE1
    // pop reads pre-incremented address, push writes current address
    assign stack_addr_o      = {STACK_PAGE, (state_reg == ST_POP) ? sp_inc(sp_reg) : sp_reg};

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_irq_start;
        state_reg == ST_IDLE && op_i == OP_IRQ;
    endsequence

    property p_ones;
        @(posedge clock_i) disable iff (rst_i) condition_flags_o[7:6] == 2'h3;
    endproperty
    a_ones: assert property (p_ones) else $error("flag bits 7:6 not one"); // RULE7

    property p_stack_page;
        @(posedge clock_i) disable iff (rst_i) stack_pointer_o[15:8] == STACK_PAGE;
    endproperty
    a_stack_page: assert property (p_stack_page) else $error("stack page moved"); // RULE15

    property p_irq_five;
        @(posedge clock_i) disable iff (rst_i)
        s_irq_start |=> stack_we_o[*5] ##1 !busy_o;
    endproperty
    a_irq_five: assert property (p_irq_five) else $error("irq push not five bytes"); // RULE20

    property p_irq_pcl_first;
        @(posedge clock_i) disable iff (rst_i)
        s_irq_start |=> stack_wdata_o == $past(pc_reg[7:0]) && stack_addr_o[7:0] == $past(sp_reg);
    endproperty
    a_irq_pcl_first: assert property (p_irq_pcl_first) else $error("pc low not first"); // RULE19

    property p_irq_sp;
        @(posedge clock_i) disable iff (rst_i)
        s_irq_start |=> ##5 sp_reg == 8'($past(sp_reg, 6) - 8'h05);
    endproperty
    a_irq_sp: assert property (p_irq_sp) else $error("sp not moved by five"); // RULE18

    property p_irq_y;
        @(posedge clock_i) disable iff (rst_i)
        s_irq_start |=> ##5 y_reg == $past(y_reg, 6);
    endproperty
    a_irq_y: assert property (p_irq_y) else $error("second index touched"); // RULE5

    property p_rsp;
        @(posedge clock_i) disable iff (rst_i)
        state_reg == ST_IDLE && op_i == OP_STACK_RESET |=> sp_reg == STACK_TOP;
    endproperty
    a_rsp: assert property (p_rsp) else $error("stack reset failed"); // RULE16

    property p_zero;
        @(posedge clock_i) disable iff (rst_i)
        state_reg == ST_IDLE && op_i == OP_LOGIC
        |=> condition_flags_o[FLAG_ZERO] == ($past(result_i) == 8'h00)
            && condition_flags_o[FLAG_NEG] == $past(result_i[7]);
    endproperty
    a_zero: assert property (p_zero) else $error("zero/negative flag wrong"); // RULE10

endmodule : cpu_core_register_set
`default_nettype wire

// *** cpu_core_register_set_tb.sv ***
/*
 * self-checking bench for the core register set: drives instruction operations
 * and checks registers, flags and stack traffic.
 * assumes cpu_regs_pkg and cpu_core_register_set are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module cpu_core_register_set_tb;
    import cpu_regs_pkg::*;
    logic clock_i = 0, rst_i = 1, prefix_i = 0, carry_in_i = 0, busy_o, stack_we_o;
    op_t op_i = OP_NONE;
    reg_sel_t dest_sel_i = SEL_ACC;
    logic [7:0] operand_i = 8'h00, result_i = 8'h00, stack_rdata_i, stack_wdata_o, read_data_o;
    logic [7:0] acc_o, index_x_o, index_y_o, condition_flags_o, mem [256];
    logic [1:0] src_prio_i = 2'h0;
    logic [15:0] target_i = 16'h1234, program_counter_o, stack_pointer_o, stack_addr_o;
    int mismatches = 0, n_compared = 0;
    cpu_core_register_set u_dut (.clock_i(clock_i), .rst_i(rst_i), .op_i(op_i),
        .dest_sel_i(dest_sel_i), .prefix_i(prefix_i), .operand_i(operand_i),
        .result_i(result_i), .carry_in_i(carry_in_i), .src_prio_i(src_prio_i),
        .target_i(target_i), .stack_rdata_i(stack_rdata_i), .busy_o(busy_o),
        .read_data_o(read_data_o), .acc_o(acc_o), .index_x_o(index_x_o),
        .index_y_o(index_y_o), .program_counter_o(program_counter_o),
        .condition_flags_o(condition_flags_o), .stack_pointer_o(stack_pointer_o),
        .stack_addr_o(stack_addr_o), .stack_wdata_o(stack_wdata_o), .stack_we_o(stack_we_o));
    always #4 clock_i = ~clock_i;  // 125 MHz
    // stack memory, written on strobe, read combinationally
    always @(posedge clock_i) if (stack_we_o) mem[stack_addr_o[7:0]] <= stack_wdata_o;
    assign stack_rdata_i = mem[stack_addr_o[7:0]];
    function automatic logic [7:0] ff(input logic [1:0] p, input logic h, n, z, c);
        return {2'b11, p[1], h, p[0], n, z, c};
    endfunction : ff
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one instruction: pulse for one cycle, then wait out any stack sequence
    task automatic op(input op_t o, input reg_sel_t s, input logic p, input logic [7:0] d);
        int n;
        @(posedge clock_i);
        op_i <= o; dest_sel_i <= s; prefix_i <= p; operand_i <= d;
        @(posedge clock_i);
        op_i <= OP_NONE;
        #1;
        n = 0;
        while (busy_o !== 1'b0 && n < 20) begin
            @(posedge clock_i); #1; n++;
        end
        if (n >= 20) chk("busy", 16'h1, 16'h0);
    endtask : op
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    initial begin #20000; mismatches++; wrap_up; end  // watchdog
    // --------------------------------------------------------------
    // test sequence
    // --------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0; #1;
        chk("flags", condition_flags_o, 8'hf8);
        chk("sp", stack_pointer_o, 16'h01ff);
        op(OP_LOAD, SEL_INDEX, 0, 8'h5a); op(OP_LOAD, SEL_INDEX, 1, 8'ha5);
        chk("x", index_x_o, 8'h5a); chk("y", index_y_o, 8'ha5);
        op(OP_LOAD, SEL_ACC, 0, 8'h0f); op(OP_ADD, SEL_ACC, 0, 8'h01);
        chk("add", {acc_o, condition_flags_o}, {8'h10, ff(3, 1, 0, 0, 0)});
        op(OP_ADD, SEL_ACC, 0, 8'hf0);
        chk("add", {acc_o, condition_flags_o}, {8'h00, ff(3, 0, 0, 1, 1)});
        op(OP_ADC, SEL_ACC, 0, 8'h7f);
        chk("adc", {acc_o, condition_flags_o}, {8'h80, ff(3, 1, 1, 0, 0)});
        op(OP_SET_CARRY, SEL_ACC, 0, 8'h00);
        chk("scf", condition_flags_o, ff(3, 1, 1, 0, 1));
        op(OP_CLR_CARRY, SEL_ACC, 0, 8'h00);
        chk("rcf", condition_flags_o, ff(3, 1, 1, 0, 0));
        for (int i = 0; i < 4; i++) begin
            op(OP_SET_PRIO, SEL_ACC, 0, 8'(i));
            chk("prio", condition_flags_o, ff(2'(i), 1, 1, 0, 0));
        end
        $display("flags test done");
        op(OP_LOAD, SEL_STACK_LOW, 0, 8'h01);
        chk("s", {read_data_o, stack_pointer_o}, 24'h010101);
        op(OP_PUSH, SEL_ACC, 0, 8'h00); chk("sp", stack_pointer_o, 16'h0100);
        op(OP_PUSH, SEL_ACC, 0, 8'h00); chk("sp", stack_pointer_o, 16'h01ff);
        op(OP_POP, SEL_ACC, 0, 8'h00);
        chk("pop", {acc_o, stack_pointer_o}, 24'h800100);
        op(OP_STACK_RESET, SEL_ACC, 0, 8'h00); chk("sp", stack_pointer_o, 16'h01ff);
        op(OP_CALL, SEL_ACC, 0, 8'h00);
        chk("call", {program_counter_o, stack_pointer_o}, 32'h123401fd);
        target_i <= 16'hbeef;
        op(OP_IRQ, SEL_ACC, 0, 8'h00);
        chk("irq", {program_counter_o, stack_pointer_o}, 32'hbeef01f8);
        chk("ctx", {mem[8'hfd], mem[8'hfc], mem[8'hfb], mem[8'hfa]}, 32'h34125a80);
        chk("ctxf", {8'h00, mem[8'hf9]}, ff(3, 1, 1, 0, 0));
        chk("prio", {index_y_o, condition_flags_o}, {8'ha5, ff(0, 1, 1, 0, 0)});
        op(OP_LOAD, SEL_INDEX, 0, 8'h33);
        op(OP_INTERRUPT_RETURN_INSTR, SEL_ACC, 0, 8'h00);
        chk("interrupt_return_instr", {program_counter_o, stack_pointer_o}, 32'h123401fd);
        chk("iretx", {index_x_o, condition_flags_o}, {8'h5a, ff(3, 1, 1, 0, 0)});
        op(OP_RET, SEL_ACC, 0, 8'h00);
        chk("ret", {program_counter_o, stack_pointer_o}, 32'h000001ff);
        // logic result, loaded carry, second index through the stack, direct loads
        result_i <= 8'h00; carry_in_i <= 1'b1;
        op(OP_LOGIC, SEL_ACC, 0, 8'h00); op(OP_CARRY_LOAD, SEL_ACC, 0, 8'h00);
        chk("logic", {acc_o, condition_flags_o}, {8'h00, ff(3, 1, 0, 1, 1)});
        op(OP_PUSH, SEL_INDEX, 1, 8'h00); op(OP_POP, SEL_ACC, 0, 8'h00);
        chk("pushy", {acc_o, stack_pointer_o}, 24'ha501ff);
        op(OP_PUSH, SEL_INDEX, 0, 8'h00); op(OP_POP, SEL_INDEX, 1, 8'h00);
        chk("popy", {index_x_o, index_y_o}, 16'h5a5a);
        op(OP_LOAD, SEL_FLAGS, 0, 8'h0a);
        chk("ldflags", condition_flags_o, ff(1, 0, 0, 1, 0));
        op(OP_LOAD, SEL_PC_HIGH, 0, 8'hc3); op(OP_LOAD, SEL_PC_LOW, 0, 8'h3c);
        chk("ldpc", {program_counter_o, read_data_o}, 24'hc33c3c);
        $display("stack test done");
        wrap_up;
    end
endmodule : cpu_core_register_set_tb
`default_nettype wire
